// ==== design/pin_port_regs.svh ====
// Summary of operation
// - per-pin direction bit, 1 drives, reset 0
// - output data byte drives output pins
// - read-only input byte shows sampled pin levels
// - any pin level change sets its flag
// - write one clears flag, zero keeps it
// - interrupt high when flag set and unmasked
// - mask bit one blocks; masks reset to ones
// - read-only fixed identification byte
`ifndef PIN_PORT_REGS_SVH
`define PIN_PORT_REGS_SVH
`define REG_IDX_IDENTITY   8'h96
`define REG_IDX_DIRECTION  8'h97
`define REG_IDX_OUT_DATA   8'h9a
`define REG_IDX_IN_DATA    8'h9b
`define REG_IDX_MASK       8'h9c
`define REG_IDX_FLAGS      8'hc0
`define RST_DIRECTION      8'h00
`define RST_OUT_DATA       8'h00
`define RST_MASK           8'hff
`define RST_FLAGS          8'h00
`define RST_SYNC           8'h00
`endif

// ==== design/pin_port_pkg.sv ====
package pin_port_pkg;
  typedef struct packed {
    logic [7:0] wr;
    logic [7:0] rd;
    logic       wen;
    logic       ren;
  } reg_access_t;
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] toggled;
  } pin_sample_t;
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;
endpackage

// ==== design/pin_input_sync.sv ====
`timescale 1ns/10ps
`include "pin_port_regs.svh"
module pin_input_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output pin_port_pkg::pin_sample_t sample
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] last_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;
  logic [WIDTH-1:0] nxt_last;

  always_comb begin
    nxt_meta = pin_in;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  // meta stage is read only by the sync stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= `RST_SYNC;
      sync_ff <= `RST_SYNC;
      last_ff <= `RST_SYNC;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  // a post-reset settle may flag pins that idle high; software clears once
  assign sample.level   = sync_ff;
  assign sample.toggled = sync_ff ^ last_ff;

  one_change_one_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    sample.toggled != '0 |=> (sample.toggled & $past(sample.toggled)) == '0)
    else $error("change pulsed twice");
endmodule

// ==== design/pin_flag_bit.sv ====
`timescale 1ns/10ps
`include "pin_port_regs.svh"
module pin_flag_bit (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic event_seen,
  input  wire logic clear_req,
  output logic      flag_ff
);
  logic nxt_flag;

  // set beats a clear in the same cycle so no change is lost
  always_comb begin
    nxt_flag = flag_ff;
    if (clear_req) begin
      nxt_flag = 1'b0;
    end
    if (event_seen) begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    event_seen |=> flag_ff)
    else $error("event lost");
  clear_works_a: assert property (@(posedge clk) disable iff (!rst_n)
    clear_req && !event_seen |=> !flag_ff)
    else $error("flag not cleared");
endmodule

// ==== design/pin_port.sv ====
`timescale 1ns/10ps
`include "pin_port_regs.svh"
module pin_port #(
  parameter int         PINS        = 8,
  parameter logic [7:0] IDENTITY_ID = 8'h5a  // arbitrary value
) (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic [7:0]      address,
  input  wire logic            read,
  input  wire logic            write,
  input  wire logic [31:0]     writedata,
  input  wire logic [3:0]      byteenable,
  output logic [31:0]          readdata,
  output logic                 waitrequest,
  input  wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0]      pin_out,
  output logic [PINS-1:0]      pin_oe,
  output logic                 pin_event_interrupt_input
);
  // address is the register index; byte address is four times it
  logic                        rst_s1_ff;
  logic                        rst_n_ff;
  pin_port_pkg::bus_state_t    state_ff;
  pin_port_pkg::bus_state_t    nxt_state;
  logic [7:0]                  direction_ff;
  logic [7:0]                  out_data_ff;
  logic [7:0]                  mask_ff;
  logic [7:0]                  nxt_direction;
  logic [7:0]                  nxt_out_data;
  logic [7:0]                  nxt_mask;
  logic [31:0]                 nxt_readdata;
  logic                        nxt_waitrequest;
  logic                        nxt_irq;
  logic [PINS-1:0]             flags;
  logic [PINS-1:0]             clear_bits;
  pin_port_pkg::pin_sample_t   sample;
  pin_port_pkg::reg_access_t   acc;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  pin_input_sync #(
    .WIDTH (PINS)
  ) u_sync (
    .clk    (clk),
    .rst_n  (rst_n_ff),
    .pin_in (pin_in),
    .sample (sample)
  );

  // request taken only in idle; waitrequest drops one cycle later
  always_comb begin
    acc.wr  = writedata[7:0];
    acc.wen = (state_ff == pin_port_pkg::BUS_IDLE) && write && byteenable[0];
    acc.ren = (state_ff == pin_port_pkg::BUS_IDLE) && read;
    acc.rd  = 8'h00;
    unique case (address)
      `REG_IDX_IDENTITY:  acc.rd = IDENTITY_ID;
      `REG_IDX_DIRECTION: acc.rd = direction_ff;
      `REG_IDX_OUT_DATA:  acc.rd = out_data_ff;
      `REG_IDX_IN_DATA:   acc.rd = sample.level;
      `REG_IDX_MASK:      acc.rd = mask_ff;
      `REG_IDX_FLAGS:     acc.rd = flags;
      default:            acc.rd = 8'h00;
    endcase
  end

  always_comb begin
    nxt_state       = state_ff;
    nxt_waitrequest = 1'b1;
    nxt_readdata    = readdata;
    unique case (state_ff)
      pin_port_pkg::BUS_IDLE: begin
        if (read || write) begin
          nxt_state       = pin_port_pkg::BUS_ANSWER;
          nxt_waitrequest = 1'b0;
          nxt_readdata    = read ? {24'h000000, acc.rd} : 32'h00000000;
        end
      end
      pin_port_pkg::BUS_ANSWER: begin
        nxt_state = pin_port_pkg::BUS_IDLE;
      end
    endcase
  end

  always_comb begin
    nxt_direction = direction_ff;
    nxt_out_data  = out_data_ff;
    nxt_mask      = mask_ff;
    clear_bits    = '0;
    if (acc.wen) begin
      unique case (address)
        `REG_IDX_DIRECTION: nxt_direction = acc.wr;
        `REG_IDX_OUT_DATA:  nxt_out_data  = acc.wr;
        `REG_IDX_MASK:      nxt_mask      = acc.wr;
        `REG_IDX_FLAGS:     clear_bits    = acc.wr;
        default:            nxt_direction = direction_ff;
      endcase
    end
    nxt_irq = |(flags & ~nxt_mask);
  end

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_flag
      pin_flag_bit u_flag (
        .clk        (clk),
        .rst_n      (rst_n_ff),
        .event_seen (sample.toggled[g]),
        .clear_req  (clear_bits[g]),
        .flag_ff    (flags[g])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff                  <= pin_port_pkg::BUS_IDLE;
      waitrequest               <= 1'b1;
      readdata                  <= 32'h00000000;
      direction_ff              <= `RST_DIRECTION;
      out_data_ff               <= `RST_OUT_DATA;
      mask_ff                   <= `RST_MASK;
      pin_out                   <= `RST_OUT_DATA;
      pin_oe                    <= `RST_DIRECTION;
      pin_event_interrupt_input <= 1'b0;
    end else begin
      state_ff                  <= nxt_state;
      waitrequest               <= nxt_waitrequest;
      readdata                  <= nxt_readdata;
      direction_ff              <= nxt_direction;
      out_data_ff               <= nxt_out_data;
      mask_ff                   <= nxt_mask;
      pin_out                   <= nxt_out_data;
      pin_oe                    <= nxt_direction;
      pin_event_interrupt_input <= nxt_irq;
    end
  end

  dir_follows_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    acc.wen && address == `REG_IDX_DIRECTION |=> pin_oe == $past(writedata[7:0]))
    else $error("direction not applied");
  out_follows_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    acc.wen && address == `REG_IDX_OUT_DATA |=> pin_out == $past(writedata[7:0]))
    else $error("output data not applied");
  input_read_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    acc.ren && address == `REG_IDX_IN_DATA |=> readdata[7:0] == $past(sample.level))
    else $error("input byte wrong");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    ##1 pin_event_interrupt_input == |($past(flags) & ~mask_ff))
    else $error("interrupt level wrong");
  mask_blocks_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    mask_ff == 8'hff |-> !pin_event_interrupt_input)
    else $error("masked flag raised interrupt");
  id_fixed_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    acc.ren && address == `REG_IDX_IDENTITY |=> readdata == {24'h000000, IDENTITY_ID})
    else $error("identity byte wrong");
  answer_once_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    !waitrequest |=> waitrequest)
    else $error("answer held two cycles");
endmodule

// ==== tb/pin_world.sv ====
`timescale 1ns/10ps
module pin_world (
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_level
);
  // a driven pin shows the port's value, an undriven one the button
  assign pin_level = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

// ==== tb/test_eight_bit_pin_port_with_edge_irq.sv ====
`timescale 1ns/10ps
`include "pin_port_regs.svh"
module test_eight_bit_pin_port_with_edge_irq;
  logic        clk         = 1'b0;
  logic        arst_n      = 1'b0;
  logic [7:0]  address     = 8'h00;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h00000000;
  logic [3:0]  byteenable  = 4'hf;
  logic [7:0]  ext_level   = 8'h00;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  pin_level;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic        irq;
  logic [7:0]  got;
  logic        wait_seen   = 1'b1;
  int          n_mismatch  = 0;
  int          checks_done = 0;
  logic [7:0]  idx_tab [6] = '{`REG_IDX_IDENTITY, `REG_IDX_DIRECTION, `REG_IDX_OUT_DATA,
                               `REG_IDX_IN_DATA, `REG_IDX_MASK, `REG_IDX_FLAGS};
  logic [7:0]  rst_tab [6] = '{8'h5a, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};

  always #2 clk = ~clk;

  // settled copy of waitrequest as it stands at the next rising edge
  always @(negedge clk) wait_seen = waitrequest;

  pin_port i_dut (
    .clk                       (clk),
    .arst_n                    (arst_n),
    .address                   (address),
    .read                      (read),
    .write                     (write),
    .writedata                 (writedata),
    .byteenable                (byteenable),
    .readdata                  (readdata),
    .waitrequest               (waitrequest),
    .pin_in                    (pin_level),
    .pin_out                   (pin_out),
    .pin_oe                    (pin_oe),
    .pin_event_interrupt_input (irq)
  );

  pin_world i_pins (
    .ext_level (ext_level),
    .pin_out   (pin_out),
    .pin_oe    (pin_oe),
    .pin_level (pin_level)
  );

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask

  // bounded so a stuck waitrequest cannot hang the run
  task automatic wait_answer;
    int n;
    n = 0;
    @(posedge clk);
    while (wait_seen !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) n_mismatch++;
  endtask

  task automatic reg_write(input logic [7:0] idx, input logic [7:0] data, input logic [3:0] be = 4'hf);
    address    <= idx;
    writedata  <= {24'h000000, data};
    byteenable <= be;
    write      <= 1'b1;
    wait_answer();
    write      <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_read(input logic [7:0] idx, output logic [7:0] data);
    address <= idx;
    read    <= 1'b1;
    wait_answer();
    data = readdata[7:0];
    read    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic expect_reg(input string what, input logic [7:0] idx, input logic [7:0] exp);
    reg_read(idx, got);
    check_byte(what, exp, got);
  endtask

  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      expect_reg("reset value", idx_tab[i], rst_tab[i]);
    end
    check_byte("irq after reset", 8'h00, {7'h00, irq});
    reg_write(`REG_IDX_IDENTITY, 8'hff);
    reg_write(`REG_IDX_IN_DATA, 8'hff);
    reg_write(`REG_IDX_DIRECTION, 8'hff, 4'he);
    reg_write(8'h00, 8'hff);
    expect_reg("identity", `REG_IDX_IDENTITY, 8'h5a);
    expect_reg("input", `REG_IDX_IN_DATA, 8'h00);
    expect_reg("direction", `REG_IDX_DIRECTION, 8'h00);
    expect_reg("unmapped", 8'h00, 8'h00);
    ext_level <= 8'h5a;
    repeat (6) @(posedge clk);
    expect_reg("input", `REG_IDX_IN_DATA, 8'h5a);
    expect_reg("flags", `REG_IDX_FLAGS, 8'h5a);
    check_byte("irq masked", 8'h00, {7'h00, irq});
    reg_write(`REG_IDX_MASK, 8'hfd);
    repeat (2) @(posedge clk);
    check_byte("irq unmasked", 8'h01, {7'h00, irq});
    reg_write(`REG_IDX_FLAGS, 8'h00);
    expect_reg("flags", `REG_IDX_FLAGS, 8'h5a);
    reg_write(`REG_IDX_FLAGS, 8'h02);
    expect_reg("flags", `REG_IDX_FLAGS, 8'h58);
    check_byte("irq cleared", 8'h00, {7'h00, irq});
    reg_write(`REG_IDX_FLAGS, 8'hff);
    expect_reg("flags", `REG_IDX_FLAGS, 8'h00);
    reg_write(`REG_IDX_DIRECTION, 8'ha5);
    reg_write(`REG_IDX_OUT_DATA, 8'h3c);
    check_byte("pin_oe", 8'ha5, pin_oe);
    check_byte("pin_out", 8'h3c, pin_out);
    expect_reg("out data", `REG_IDX_OUT_DATA, 8'h3c);
    repeat (6) @(posedge clk);
    expect_reg("input", `REG_IDX_IN_DATA, 8'h7e);
    expect_reg("flags", `REG_IDX_FLAGS, 8'h24);
    reg_write(`REG_IDX_MASK, 8'h00);
    repeat (2) @(posedge clk);
    check_byte("irq all enabled", 8'h01, {7'h00, irq});
    reg_write(`REG_IDX_FLAGS, 8'hff);
    repeat (2) @(posedge clk);
    check_byte("irq after clear", 8'h00, {7'h00, irq});
    summarize();
  end
endmodule
